// ### pkg/pcm_ctrl_pkg.sv
// Summary of operation
// - Maintenance code 010 sends Halt line state
// - Maintenance code 011 sends Master line state
// - Codes 100, 101, 111 send Quiet
// - Code 110 passes transmit data symbols
// - Single attach keeps station inserted before ACTIVE
// - Single attach ignored for bypass in maintenance
// - Maintenance bypass follows companion register bits
// - Single attach bit changes only in OFF
// - Writes outside OFF leave it unchanged
// - Nonzero loopback in NEXT, not signalling and armed by reset or a 00 write, starts confidence test
// - Loopback 00 performs no confidence test
// - Maintenance field picks sourced line state
// - Maintenance code 001 sends Idle line state
// - Loopback 01 data, 10 Idle, 11 remote
package pcm_ctrl_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  CMC_OFFSET      = 8'h00;
    localparam logic [7:0]  COMPANION_OFFSET = 8'h04;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h08;
    localparam int          CMC_W           = 16;

    localparam int          MAINTENANCE_LINE_STATE_SELECT_LSB    = 8;
    localparam int          CLASS_BIT       = 7;
    localparam int          LOOP_LSB        = 5;
    localparam int          SCRUB_BIT       = 1;
    localparam int          BYPASS_BIT      = 0;
    localparam int          STAT_SRC_LSB    = 0;
    localparam int          STAT_ARMED_BIT  = 5;
    localparam int          STAT_LCT_BIT    = 6;
    localparam int          STAT_BYPASS_BIT = 7;

    localparam logic [2:0]  MAINTENANCE_LINE_STATE_SELECT_RESET  = 3'h0;
    localparam logic [1:0]  LOOP_RESET      = 2'h0;

    // ************************************************************
    // Field codes
    // ************************************************************
    localparam logic [2:0]  LS_QUIET0       = 3'h0;
    localparam logic [2:0]  LS_IDLE         = 3'h1;
    localparam logic [2:0]  LS_HALT         = 3'h2;
    localparam logic [2:0]  LS_MASTER       = 3'h3;
    localparam logic [2:0]  LS_DATA         = 3'h6;
    localparam logic [1:0]  LOOP_NONE       = 2'h0;
    localparam logic [1:0]  LOOP_DATA       = 2'h1;
    localparam logic [1:0]  LOOP_IDLE       = 2'h2;
    localparam logic [1:0]  LOOP_REMOTE     = 2'h3;

    // Symbol pairs: Quiet 00000, Idle 11111, Halt 00100, Master = Halt then Quiet
    localparam logic [9:0]  SYM_QUIET       = 10'h000;
    localparam logic [9:0]  SYM_IDLE        = 10'h3ff;
    localparam logic [9:0]  SYM_HALT        = 10'h084;
    localparam logic [9:0]  SYM_MASTER      = 10'h080;

    typedef enum logic [9:0] {
        PCM_OFF     = 10'h001,
        PCM_BREAK   = 10'h002,
        PCM_TRACE   = 10'h004,
        PCM_CONNECT = 10'h008,
        PCM_NEXT    = 10'h010,
        PCM_SIGNAL  = 10'h020,
        PCM_JOIN    = 10'h040,
        PCM_VERIFY  = 10'h080,
        PCM_ACTIVE  = 10'h100,
        PCM_MAINTENANCE_STATE   = 10'h200
    } pcm_state_e;

    typedef enum logic [4:0] {
        TXS_QUIET  = 5'h01,
        TXS_IDLE   = 5'h02,
        TXS_HALT   = 5'h04,
        TXS_MASTER = 5'h08,
        TXS_DATA   = 5'h10
    } tx_src_e;

    typedef struct packed {
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
    } reg_write_s;

    typedef struct packed {
        logic       active;
        logic [1:0] mode;
    } lct_s;

    function automatic tx_src_e maintenance_state_source(input logic [2:0] ls);
        case (ls)
            LS_IDLE:   maintenance_state_source = TXS_IDLE;
            LS_HALT:   maintenance_state_source = TXS_HALT;
            LS_MASTER: maintenance_state_source = TXS_MASTER;
            LS_DATA:   maintenance_state_source = TXS_DATA;
            default:   maintenance_state_source = TXS_QUIET;
        endcase
    endfunction

endpackage

// ### src/pcm_apb_port.sv
`timescale 1ns/10ps
module pcm_apb_port
    import pcm_ctrl_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [31:0]       read_value,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [ADDR_W-1:0]      read_addr,
    output reg_write_s             reg_write
);

    // ************************************************************
    // Setup-phase capture
    // ************************************************************
    // Read data is latched in setup so the access phase never waits
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        err_reg;
    logic        err_next;
    logic        setup;
    logic        mapped;

    assign setup     = psel && !penable;
    assign mapped    = (paddr == CMC_OFFSET) || (paddr == COMPANION_OFFSET)
                       || (paddr == STATUS_OFFSET);
    assign read_addr = paddr;

    always_comb
    begin
        prdata_next = prdata_reg;
        err_next    = err_reg;
        if (setup)
        begin
            prdata_next = (!pwrite && mapped) ? read_value : 32'h0000_0000;
            err_next    = !mapped;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            prdata_reg <= 32'h0000_0000;
            err_reg    <= 1'b0;
        end
        else
        begin
            prdata_reg <= prdata_next;
            err_reg    <= err_next;
        end
    end

    assign prdata          = prdata_reg;
    assign pready          = 1'b1;
    assign pslverr         = psel && penable && err_reg;
    // One driver for the whole carrier; the write lands in the access cycle
    assign reg_write = '{wr_en: psel && penable && pwrite && mapped,
                         addr:  paddr,
                         wdata: pwdata};

endmodule

// ### src/pcm_tx_source.sv
`timescale 1ns/10ps
module pcm_tx_source
    import pcm_ctrl_pkg::*;
#(
    parameter int DATA_W = 10
)
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire pcm_state_e        pcm_state,
    input  wire logic [2:0]        maintenance_state_line_state,
    input  wire lct_s              lct,
    input  wire logic [DATA_W-1:0] tx_data_in,
    output logic [DATA_W-1:0]      tx_symbol_out,
    output tx_src_e                tx_source
);

    // ************************************************************
    // Source selection
    // ************************************************************
    tx_src_e             src_reg;
    tx_src_e             src_next;
    logic [DATA_W-1:0]   sym_reg;
    logic [DATA_W-1:0]   sym_next;

    always_comb
    begin
        if (pcm_state == PCM_MAINTENANCE_STATE)
            src_next = maintenance_state_source(maintenance_state_line_state);
        else if (lct.active && lct.mode == LOOP_IDLE)
            src_next = TXS_IDLE;
        else
            src_next = TXS_DATA;
        case (src_next)
            TXS_IDLE:   sym_next = DATA_W'(SYM_IDLE);
            TXS_HALT:   sym_next = DATA_W'(SYM_HALT);
            TXS_MASTER: sym_next = DATA_W'(SYM_MASTER);
            TXS_DATA:   sym_next = tx_data_in;
            default:    sym_next = DATA_W'(SYM_QUIET);
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            src_reg <= TXS_QUIET;
            sym_reg <= '0;
        end
        else
        begin
            src_reg <= src_next;
            sym_reg <= sym_next;
        end
    end

    assign tx_symbol_out = sym_reg;
    assign tx_source     = src_reg;

endmodule

// ### src/pcm_maintenance_state_lct_control.sv
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module pcm_maintenance_state_lct_control
    import pcm_ctrl_pkg::*;
#(
    parameter int DATA_W = 10
)
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire pcm_state_e        pcm_state,
    input  wire logic              pcm_signaling,
    input  wire logic [DATA_W-1:0] tx_data_in,
    output logic [DATA_W-1:0]      tx_symbol_out,
    output logic                   lct_start,
    output logic [1:0]             lct_loopback,
    output logic                   lct_active,
    output logic                   remote_loopback_en,
    output logic                   station_bypass,
    output logic                   scrub_request_out
);

    // ************************************************************
    // Bus port
    // ************************************************************
    reg_write_s        reg_write;
    logic [ADDR_W-1:0] read_addr;
    logic [31:0]       read_value;

    pcm_apb_port u_apb
    (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .pwdata     (pwdata),
        .read_value (read_value),
        .prdata     (prdata),
        .pready     (pready),
        .pslverr    (pslverr),
        .read_addr  (read_addr),
        .reg_write  (reg_write)
    );

    // ************************************************************
    // Control registers
    // ************************************************************
    logic [2:0] maintenance_line_state_select_reg;
    logic [2:0] maintenance_line_state_select_next;
    logic       class_reg;
    logic       class_next;
    logic [1:0] loop_reg;
    logic [1:0] loop_next;
    logic       armed_reg;
    logic       armed_next;
    logic       scrub_reg;
    logic       scrub_next;
    logic       bypass_ctl_reg;
    logic       bypass_ctl_next;
    lct_s       lct_reg;
    lct_s       lct_next;
    logic       start_reg;
    logic       start_next;
    logic       cmc_wr;
    logic       comp_wr;
    logic       loop_ok;
    logic [1:0] loop_wr;

    assign cmc_wr  = reg_write.wr_en && reg_write.addr == CMC_OFFSET;
    assign comp_wr = reg_write.wr_en && reg_write.addr == COMPANION_OFFSET;
    // Loopback writes outside NEXT or during signalling are dropped
    assign loop_ok = pcm_state == PCM_NEXT && !pcm_signaling;
    assign loop_wr = reg_write.wdata[LOOP_LSB +: 2];

    always_comb
    begin
        maintenance_line_state_select_next   = maintenance_line_state_select_reg;
        class_next      = class_reg;
        loop_next       = loop_reg;
        armed_next      = armed_reg;
        scrub_next      = scrub_reg;
        bypass_ctl_next = bypass_ctl_reg;
        lct_next        = lct_reg;
        start_next      = 1'b0;
        // The test lives only inside NEXT; leaving it ends it
        if (pcm_state != PCM_NEXT)
            lct_next.active = 1'b0;
        if (cmc_wr)
        begin
            maintenance_line_state_select_next = reg_write.wdata[MAINTENANCE_LINE_STATE_SELECT_LSB +: 3];
            if (pcm_state == PCM_OFF)
                class_next = reg_write.wdata[CLASS_BIT];
            if (loop_ok)
            begin
                loop_next = loop_wr;
                if (loop_wr == LOOP_NONE)
                    armed_next = 1'b1;
                else if (armed_reg)
                begin
                    armed_next      = 1'b0;
                    start_next      = 1'b1;
                    lct_next.active = 1'b1;
                    lct_next.mode   = loop_wr;
                end
            end
        end
        if (comp_wr)
        begin
            scrub_next      = reg_write.wdata[SCRUB_BIT];
            bypass_ctl_next = reg_write.wdata[BYPASS_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            maintenance_line_state_select_reg   <= MAINTENANCE_LINE_STATE_SELECT_RESET;
            class_reg      <= 1'b0;
            loop_reg       <= LOOP_RESET;
            armed_reg      <= 1'b1;
            scrub_reg      <= 1'b0;
            bypass_ctl_reg <= 1'b0;
            lct_reg        <= '0;
            start_reg      <= 1'b0;
        end
        else
        begin
            maintenance_line_state_select_reg   <= maintenance_line_state_select_next;
            class_reg      <= class_next;
            loop_reg       <= loop_next;
            armed_reg      <= armed_next;
            scrub_reg      <= scrub_next;
            bypass_ctl_reg <= bypass_ctl_next;
            lct_reg        <= lct_next;
            start_reg      <= start_next;
        end
    end

    assign lct_start          = start_reg;
    assign lct_loopback       = lct_reg.mode;
    assign lct_active         = lct_reg.active;
    assign remote_loopback_en = lct_reg.active && lct_reg.mode == LOOP_REMOTE;

    // ************************************************************
    // Bypass control
    // ************************************************************
    logic bypass_reg;
    logic bypass_next;
    logic scrub_out_reg;
    logic scrub_out_next;

    always_comb
    begin
        scrub_out_next = 1'b0;
        if (pcm_state == PCM_MAINTENANCE_STATE)
        begin
            bypass_next    = bypass_ctl_reg;
            scrub_out_next = scrub_reg;
        end
        else if (class_reg)
            bypass_next = 1'b0;
        else
            bypass_next = pcm_state != PCM_ACTIVE;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bypass_reg    <= 1'b1;
            scrub_out_reg <= 1'b0;
        end
        else
        begin
            bypass_reg    <= bypass_next;
            scrub_out_reg <= scrub_out_next;
        end
    end

    assign station_bypass    = bypass_reg;
    assign scrub_request_out = scrub_out_reg;

    // ************************************************************
    // Transmit path
    // ************************************************************
    tx_src_e tx_source;

    pcm_tx_source #(.DATA_W(DATA_W)) u_tx
    (
        .sys_clk          (sys_clk),
        .srst             (srst),
        .pcm_state        (pcm_state),
        .maintenance_state_line_state (maintenance_line_state_select_reg),
        .lct              (lct_reg),
        .tx_data_in       (tx_data_in),
        .tx_symbol_out    (tx_symbol_out),
        .tx_source        (tx_source)
    );

    // ************************************************************
    // Read mux
    // ************************************************************
    always_comb
    begin
        read_value = 32'h0000_0000;
        case (read_addr)
            CMC_OFFSET:
            begin
                read_value[MAINTENANCE_LINE_STATE_SELECT_LSB +: 3] = maintenance_line_state_select_reg;
                read_value[CLASS_BIT]         = class_reg;
                read_value[LOOP_LSB +: 2]     = loop_reg;
            end
            COMPANION_OFFSET:
            begin
                read_value[SCRUB_BIT]  = scrub_reg;
                read_value[BYPASS_BIT] = bypass_ctl_reg;
            end
            STATUS_OFFSET:
            begin
                read_value[STAT_SRC_LSB +: 5] = tx_source;
                read_value[STAT_ARMED_BIT]    = armed_reg;
                read_value[STAT_LCT_BIT]      = lct_reg.active;
                read_value[STAT_BYPASS_BIT]   = bypass_reg;
            end
            default: read_value = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    a_maintenance_state_halt_out: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE && maintenance_line_state_select_reg == LS_HALT
        |=> tx_symbol_out == DATA_W'(SYM_HALT))
        else $error("Halt not sent in maintenance");

    a_maintenance_state_master_out: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE && maintenance_line_state_select_reg == LS_MASTER
        |=> tx_symbol_out == DATA_W'(SYM_MASTER))
        else $error("Master not sent in maintenance");

    a_maintenance_state_quiet_out: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE && maintenance_line_state_select_reg[2] && maintenance_line_state_select_reg != LS_DATA
        |=> tx_symbol_out == DATA_W'(SYM_QUIET))
        else $error("Quiet not sent in maintenance");

    a_maintenance_state_data_pass: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE && maintenance_line_state_select_reg == LS_DATA
        |=> tx_symbol_out == $past(tx_data_in))
        else $error("Transmit data not passed");

    a_class_no_bypass: assert property (@(posedge sys_clk) disable iff (srst)
        class_reg && pcm_state != PCM_MAINTENANCE_STATE |=> !station_bypass)
        else $error("Single attach station bypassed");

    a_maintenance_state_bypass_src: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE
        |=> station_bypass == $past(bypass_ctl_reg) && scrub_request_out == $past(scrub_reg))
        else $error("Maintenance bypass not from companion bits");

    a_class_held: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state != PCM_OFF |=> $stable(class_reg))
        else $error("Class bit changed outside OFF");

    a_loop_start: assert property (@(posedge sys_clk) disable iff (srst)
        cmc_wr && loop_ok && armed_reg && loop_wr != LOOP_NONE
        |=> lct_start && lct_active && lct_loopback == $past(loop_wr) ##1 !lct_start)
        else $error("Confidence test not started");

    a_loop_none: assert property (@(posedge sys_clk) disable iff (srst)
        cmc_wr && loop_wr == LOOP_NONE |=> !lct_start)
        else $error("Test started on zero loopback");

    a_maintenance_state_idle_out: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE && maintenance_line_state_select_reg == LS_IDLE
        |=> tx_symbol_out == DATA_W'(SYM_IDLE))
        else $error("Idle not sent in maintenance");

    a_loop_idle_src: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state != PCM_MAINTENANCE_STATE && lct_reg.active && lct_reg.mode == LOOP_IDLE
        |=> tx_symbol_out == DATA_W'(SYM_IDLE))
        else $error("Idle not sourced in confidence test");

    a_normal_data_pass: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state != PCM_MAINTENANCE_STATE && !(lct_reg.active && lct_reg.mode == LOOP_IDLE)
        |=> tx_symbol_out == $past(tx_data_in))
        else $error("Transmit data not passed outside maintenance");

    a_maintenance_state_class_free: assert property (@(posedge sys_clk) disable iff (srst)
        pcm_state == PCM_MAINTENANCE_STATE && class_reg && bypass_ctl_reg |=> station_bypass)
        else $error("Single attach blocked maintenance bypass");

    a_class_off_load: assert property (@(posedge sys_clk) disable iff (srst)
        cmc_wr && pcm_state == PCM_OFF && reg_write.wdata[CLASS_BIT] |=> class_reg)
        else $error("Class bit not taken in OFF");

    a_lct_ends: assert property (@(posedge sys_clk) disable iff (srst)
        lct_active && pcm_state != PCM_NEXT |=> !lct_active)
        else $error("Confidence test outlived NEXT");

endmodule

// ### testbench/nbr_station_model.sv
`timescale 1ns/10ps
module nbr_station_model
    import pcm_ctrl_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic [9:0] rx_pair,
    output logic [2:0]      line_seen
);
    // ************************************************************
    // Line state receiver
    // ************************************************************
    // One pair decides here; a real receiver needs a run of pairs, which only slows the bench
    always_ff @(posedge sys_clk)
    begin
        case (rx_pair)
            SYM_QUIET:  line_seen <= 3'h0;
            SYM_IDLE:   line_seen <= 3'h1;
            SYM_HALT:   line_seen <= 3'h2;
            SYM_MASTER: line_seen <= 3'h3;
            default:    line_seen <= 3'h7;
        endcase
    end
endmodule

// ### testbench/pcm_maintenance_state_lct_control_bench.sv
`timescale 1ns/10ps
module pcm_maintenance_state_lct_control_bench;
    import pcm_ctrl_pkg::*;
    logic       sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic       pcm_signaling = 1'b0, pready, pslverr, lct_start, lct_active, err;
    logic       remote_loopback_en, station_bypass, scrub_request_out;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic [9:0] tx_data_in = 10'h000, tx_symbol_out;
    logic [1:0] lct_loopback;
    logic [2:0] line_seen;
    pcm_state_e pcm_state = PCM_OFF;
    int         n_mismatch = 0, n_tests = 0, cls = 0, mls = 0, lpf = 0, armed = 1;
    int         lm = 0, la = 0, comp = 0, exp_pulse = 0, pulses;

    pcm_maintenance_state_lct_control #(.DATA_W(10)) u_dut (.sys_clk(sys_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pcm_state(pcm_state),
        .pcm_signaling(pcm_signaling), .tx_data_in(tx_data_in), .tx_symbol_out(tx_symbol_out),
        .lct_start(lct_start), .lct_loopback(lct_loopback), .lct_active(lct_active),
        .remote_loopback_en(remote_loopback_en), .station_bypass(station_bypass),
        .scrub_request_out(scrub_request_out));
    nbr_station_model u_nbr (.sys_clk(sys_clk), .rx_pair(tx_symbol_out), .line_seen(line_seen));

    always #4 sys_clk = ~sys_clk;

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic finish_test;
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Request held until pready is sampled high; no wait count assumed
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        // A release still pending from the last call: let one edge pass first
        if (psel === 1'b1)
            @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            check("pready", 1'b0, 1'b1);
        q   = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("readback", q, exp);
    endtask

    // Model update follows the write, then start pulses are counted over four edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        exp_pulse = 0;
        if (a == 8'h04)
            comp = int'(d[1:0]);
        if (a == 8'h00)
        begin
            mls = int'(d[10:8]);
            if (pcm_state == PCM_OFF)
                cls = int'(d[7]);
            if (pcm_state == PCM_NEXT && !pcm_signaling)
            begin
                lpf = int'(d[6:5]);
                if (lpf == 0)
                    armed = 1;
                else if (armed != 0)
                begin
                    lm = lpf;
                    la = 1;
                    armed = 0;
                    exp_pulse = 1;
                end
            end
        end
        pulses = 0;
        repeat (4)
        begin
            @(posedge sys_clk);
            if (lct_start === 1'b1)
                pulses++;
        end
        check("lct_start", 32'(pulses), 32'(exp_pulse));
    endtask

    function automatic logic [9:0] exp_tx(input logic mt, input logic [9:0] d);
        if (!mt)
            return (la != 0 && lm == 2) ? SYM_IDLE : d;
        case (mls)
            1: return SYM_IDLE;
            2: return SYM_HALT;
            3: return SYM_MASTER;
            6: return d;
            default: return SYM_QUIET;
        endcase
    endfunction

    task automatic set_state(input pcm_state_e s);
        logic mt;
        logic [9:0] d;
        mt = (s == PCM_MAINTENANCE_STATE);
        d  = 10'($urandom);
        pcm_state  <= s;
        tx_data_in <= d;
        if (s != PCM_NEXT)
            la = 0;
        repeat (3) @(posedge sys_clk);
        check("tx", tx_symbol_out, exp_tx(mt, d));
        check("bypass", station_bypass, mt ? comp % 2 : (cls != 0 ? 0 : s != PCM_ACTIVE));
        check("scrub", scrub_request_out, mt ? comp / 2 : 0);
        check("lct_active", lct_active, 32'(la));
        check("loop_mode", lct_loopback, 32'(lm));
        check("remote", remote_loopback_en, 32'(la != 0 && lm == 3));
        if (mt && mls != 6)
            check("line", line_seen, (mls >= 1 && mls <= 3) ? mls : 0);
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        void'($urandom(92));
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        check("bypass_reset", station_bypass, 1'b1);
        rd_chk(8'h00, 32'h0);
        rd_chk(8'h04, 32'h0);
        apb(1'b1, 8'h0c, 32'hffff_ffff);
        check("slverr", err, 1'b1);
        rd_chk(8'h00, 32'h0);
        // Class bit set throughout so a leak into maintenance bypass shows
        for (int c = 0; c < 8; c++)
        begin
            set_state(PCM_OFF);
            wr(8'h00, 32'(c << 8) | 32'h80);
            wr(8'h04, 32'($urandom % 4));
            set_state(PCM_MAINTENANCE_STATE);
            rd_chk(8'h00, 32'(c << 8) | 32'h80);
        end
        set_state(PCM_BREAK);
        wr(8'h00, 32'h0);
        rd_chk(8'h00, 32'h80);
        set_state(PCM_ACTIVE);
        set_state(PCM_OFF);
        wr(8'h00, 32'h0);
        set_state(PCM_BREAK);
        set_state(PCM_ACTIVE);
        for (int m = 1; m < 4; m++)
        begin
            set_state(PCM_NEXT);
            wr(8'h00, 32'h0);
            wr(8'h00, 32'(m << 5));
            set_state(PCM_NEXT);
            wr(8'h00, 32'(m << 5));
            rd_chk(8'h00, 32'(m << 5));
            set_state(PCM_SIGNAL);
        end
        set_state(PCM_NEXT);
        pcm_signaling <= 1'b1;
        wr(8'h00, 32'h0);
        wr(8'h00, 32'h20);
        rd_chk(8'h00, 32'h60);
        pcm_signaling <= 1'b0;
        set_state(PCM_OFF);
        rd_chk(8'h08, 32'h90);
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_mismatch++;
        finish_test;
    end
endmodule
